// [design/rfs_regs.vh]
// constant definitions for the run and frequency source selector
`ifndef RFS_REGS_VH
`define RFS_REGS_VH

// multi-input terminal layout
`define RFS_NUM_TERMINALS   8
`define RFS_FUNC_W          5
`define RFS_FUNC_SECONDARY  5'h16

// run source codes
`define RFS_RUN_W           3
`define RFS_RUN_KEYPAD      3'h0
`define RFS_RUN_TERM_FR     3'h1
`define RFS_RUN_TERM_RD     3'h2
`define RFS_RUN_SERIAL      3'h3
`define RFS_RUN_FIELDBUS    3'h4

// frequency source codes
`define RFS_FRQ_W           4
`define RFS_FRQ_KEYPAD1     4'h0
`define RFS_FRQ_KEYPAD2     4'h1
`define RFS_FRQ_V_BIPOLAR   4'h2
`define RFS_FRQ_V_UNIPOLAR  4'h3
`define RFS_FRQ_CURRENT     4'h4
`define RFS_FRQ_VBI_PLUS_I  4'h5
`define RFS_FRQ_VUNI_PLUS_I 4'h6
`define RFS_FRQ_RS485       4'h7
`define RFS_FRQ_UPDOWN      4'h8
`define RFS_FRQ_FIELDBUS    4'h9

// data widths
`define RFS_IN_W            16
`define RFS_OUT_W           18
`define RFS_STOP_W          2

// reset values
`define RFS_RESET_RUN       3'h1
`define RFS_RESET_FRQ       4'h0
`define RFS_RESET_STOP      2'h0
`define RFS_ZERO_OUT        18'h00000

`endif

// [design/rfs_freq_mux.v]
// frequency reference selection from the active frequency source code
`timescale 1ns/10ps
`default_nettype none
`include "rfs_regs.vh"

module rfs_freq_mux
(
   input  wire [`RFS_FRQ_W-1:0] freq_source,
   input  wire [`RFS_IN_W-1:0]  keypad_freq_one,
   input  wire [`RFS_IN_W-1:0]  keypad_freq_two,
   input  wire [`RFS_IN_W-1:0]  voltage_ref_input,
   input  wire [`RFS_IN_W-1:0]  current_ref_input,
   input  wire [`RFS_IN_W-1:0]  rs485_freq,
   input  wire [`RFS_IN_W-1:0]  updown_freq,
   input  wire [`RFS_IN_W-1:0]  fieldbus_freq,
   output reg  [`RFS_OUT_W-1:0] freq_value,
   output reg                   freq_code_valid
);

   wire [`RFS_OUT_W-1:0] volt_bipolar;
   wire [`RFS_OUT_W-1:0] volt_unipolar;
   wire [`RFS_OUT_W-1:0] current_ext;

   // voltage is two's complement, everything else unsigned
   assign volt_bipolar  = {{2{voltage_ref_input[`RFS_IN_W-1]}}, voltage_ref_input};
   // unipolar range: negative volts clamp to zero
   assign volt_unipolar = voltage_ref_input[`RFS_IN_W-1] ? `RFS_ZERO_OUT : volt_bipolar;
   assign current_ext   = {2'h0, current_ref_input};

   // two extra bits keep the sums from overflowing
   always @*
   begin
      freq_code_valid = 1'b1;
      case (freq_source)
         `RFS_FRQ_KEYPAD1     : freq_value = {2'h0, keypad_freq_one};
         `RFS_FRQ_KEYPAD2     : freq_value = {2'h0, keypad_freq_two};
         `RFS_FRQ_V_BIPOLAR   : freq_value = volt_bipolar;
         `RFS_FRQ_V_UNIPOLAR  : freq_value = volt_unipolar;
         `RFS_FRQ_CURRENT     : freq_value = current_ext;
         `RFS_FRQ_VBI_PLUS_I  : freq_value = volt_bipolar + current_ext;
         `RFS_FRQ_VUNI_PLUS_I : freq_value = volt_unipolar + current_ext;
         `RFS_FRQ_RS485       : freq_value = {2'h0, rs485_freq};
         `RFS_FRQ_UPDOWN      : freq_value = {2'h0, updown_freq};
         `RFS_FRQ_FIELDBUS    : freq_value = {2'h0, fieldbus_freq};
         default :
         begin
            // unknown code gives zero rather than a stale reference
            freq_value      = `RFS_ZERO_OUT;
            freq_code_valid = 1'b0;
         end
      endcase
   end

endmodule
`default_nettype wire

// [design/rfs_select.v]
// run command and frequency reference source selector with stop sequencing
`timescale 1ns/10ps
`default_nettype none
`include "rfs_regs.vh"

module rfs_select
(
   input  wire                                            clock,
   input  wire                                            rst,
   // multi-function input terminals and their function codes
   input  wire [`RFS_NUM_TERMINALS-1:0]                   multi_inputs,
   input  wire [`RFS_NUM_TERMINALS*`RFS_FUNC_W-1:0]       multi_input_function_selects,
   // source settings
   input  wire [`RFS_RUN_W-1:0]                           primary_run_source,
   input  wire [`RFS_FRQ_W-1:0]                           primary_freq_source,
   input  wire [`RFS_RUN_W-1:0]                           secondary_run_source,
   input  wire [`RFS_FRQ_W-1:0]                           secondary_freq_source,
   input  wire [`RFS_STOP_W-1:0]                          stop_method_select,
   // keypad run sources
   input  wire                                            keypad_run_key,
   input  wire                                            keypad_stop_key,
   input  wire                                            keypad_reverse,
   // control terminal run sources
   input  wire                                            forward_run_input,
   input  wire                                            reverse_run_input,
   // serial and fieldbus run sources
   input  wire                                            serial_run,
   input  wire                                            serial_reverse,
   input  wire                                            fieldbus_run,
   input  wire                                            fieldbus_reverse,
   // frequency sources
   input  wire [`RFS_IN_W-1:0]                            keypad_freq_one,
   input  wire [`RFS_IN_W-1:0]                            keypad_freq_two,
   input  wire [`RFS_IN_W-1:0]                            voltage_ref_input,
   input  wire [`RFS_IN_W-1:0]                            current_ref_input,
   input  wire [`RFS_IN_W-1:0]                            rs485_freq,
   input  wire [`RFS_IN_W-1:0]                            updown_freq,
   input  wire [`RFS_IN_W-1:0]                            fieldbus_freq,
   // motor status from the output stage
   input  wire                                            motor_stopped,
   // results
   output reg                                             secondary_active,
   output reg  [`RFS_RUN_W-1:0]                           active_run_source,
   output reg  [`RFS_FRQ_W-1:0]                           active_freq_source,
   output reg                                             run_command,
   output reg                                             reverse_command,
   output reg  [`RFS_OUT_W-1:0]                           freq_reference,
   output reg                                             decel_request,
   output reg  [`RFS_STOP_W-1:0]                          decel_method,
   output reg                                             source_switched,
   output reg                                             source_code_error
);

   // one-hot motor sequencing states
   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_RUN   = 3'h2;
   localparam [2:0] ST_DECEL = 3'h4;

   reg  [2:0]                      state;
   reg  [2:0]                      next_state;
   reg                             keypad_latch;
   reg                             next_keypad_latch;
   wire [`RFS_NUM_TERMINALS-1:0]   secondary_hits;
   wire                            secondary_now;
   wire [`RFS_RUN_W-1:0]           run_source_now;
   wire [`RFS_FRQ_W-1:0]           freq_source_now;
   reg                             run_now;
   reg                             reverse_now;
   reg                             run_code_valid;
   wire [`RFS_OUT_W-1:0]           freq_now;
   wire                            freq_code_valid;

   // each terminal votes when coded for secondary switching and asserted
   genvar t;
   generate
      for (t = 0; t < `RFS_NUM_TERMINALS; t = t + 1)
      begin : g_term
         assign secondary_hits[t] = multi_inputs[t] &
            (multi_input_function_selects[t*`RFS_FUNC_W +: `RFS_FUNC_W] == `RFS_FUNC_SECONDARY);
      end
   endgenerate

   // several terminals may carry the function; any one of them switches
   assign secondary_now = |secondary_hits;

   // source set chosen from the live terminal level, no latching
   assign run_source_now  = secondary_now ? secondary_run_source  : primary_run_source;
   assign freq_source_now = secondary_now ? secondary_freq_source : primary_freq_source;

   // keypad run latch: stop key beats run key when both pressed
   always @*
   begin
      next_keypad_latch = keypad_latch;
      if (keypad_stop_key)
      begin
         next_keypad_latch = 1'b0;
      end
      else if (keypad_run_key)
      begin
         next_keypad_latch = 1'b1;
      end
   end

   // run command and direction from the active run source
   always @*
   begin
      run_now        = 1'b0;
      reverse_now    = 1'b0;
      run_code_valid = 1'b1;
      case (run_source_now)
         `RFS_RUN_KEYPAD :
         begin
            // keys only; terminals are ignored here
            run_now     = next_keypad_latch;
            reverse_now = keypad_reverse;
         end
         `RFS_RUN_TERM_FR :
         begin
            // both terminals on is contradictory, treated as stop
            run_now     = forward_run_input ^ reverse_run_input;
            reverse_now = reverse_run_input & ~forward_run_input;
         end
         `RFS_RUN_TERM_RD :
         begin
            run_now     = forward_run_input;
            reverse_now = reverse_run_input;
         end
         `RFS_RUN_SERIAL :
         begin
            run_now     = serial_run;
            reverse_now = serial_reverse;
         end
         `RFS_RUN_FIELDBUS :
         begin
            run_now     = fieldbus_run;
            reverse_now = fieldbus_reverse;
         end
         default :
         begin
            // unknown code must never start the motor
            run_code_valid = 1'b0;
         end
      endcase
   end

   // frequency reference from the active frequency source
   rfs_freq_mux u_freq_mux
   (
      .freq_source       (freq_source_now),
      .keypad_freq_one   (keypad_freq_one),
      .keypad_freq_two   (keypad_freq_two),
      .voltage_ref_input (voltage_ref_input),
      .current_ref_input (current_ref_input),
      .rs485_freq        (rs485_freq),
      .updown_freq       (updown_freq),
      .fieldbus_freq     (fieldbus_freq),
      .freq_value        (freq_now),
      .freq_code_valid   (freq_code_valid)
   );

   // motor sequencing: losing the run command always ends in a ramp
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE :
         begin
            if (run_now)
            begin
               next_state = ST_RUN;
            end
         end
         ST_RUN :
         begin
            // a switch that keeps the command true leaves this state alone
            if (!run_now)
            begin
               next_state = ST_DECEL;
            end
         end
         ST_DECEL :
         begin
            // a fresh run command during the ramp resumes running
            if (run_now)
            begin
               next_state = ST_RUN;
            end
            else if (motor_stopped)
            begin
               next_state = ST_IDLE;
            end
         end
         default :
         begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // state and keypad latch
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state        <= ST_IDLE;
         keypad_latch <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         keypad_latch <= next_keypad_latch;
      end
   end

   // registered outputs refreshed every cycle, except reverse_command which updates only while running
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         secondary_active   <= 1'b0;
         active_run_source  <= `RFS_RESET_RUN;
         active_freq_source <= `RFS_RESET_FRQ;
         run_command        <= 1'b0;
         reverse_command    <= 1'b0;
         freq_reference     <= `RFS_ZERO_OUT;
         source_switched    <= 1'b0;
         source_code_error  <= 1'b0;
      end
      else
      begin
         secondary_active   <= secondary_now;
         active_run_source  <= run_source_now;
         active_freq_source <= freq_source_now;
         run_command        <= run_now;
         // direction holds during the ramp so the motor slows the way it ran
         if (run_now)
         begin
            reverse_command <= reverse_now;
         end
         freq_reference     <= freq_now;
         // one-cycle pulse on each change of source set
         source_switched    <= secondary_now ^ secondary_active;
         source_code_error  <= ~run_code_valid | ~freq_code_valid;
      end
   end

   // deceleration request carries the stop method chosen by the user
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         decel_request <= 1'b0;
         decel_method  <= `RFS_RESET_STOP;
      end
      else
      begin
         decel_request <= (next_state == ST_DECEL);
         // method sampled as the ramp begins so a later change cannot upset it
         if ((state == ST_RUN) && (next_state == ST_DECEL))
         begin
            decel_method <= stop_method_select;
         end
      end
   end

endmodule
`default_nettype wire

// [tb/rfs_motor_model.sv]
// output stage model that reports zero speed some cycles after run drops
`timescale 1ns/10ps
`default_nettype none
module rfs_motor_model
#(
   parameter STOP_CYCLES = 6
)
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic run_command,
   output var  logic motor_stopped
);
   integer coast;
   // coasting takes a while, so a stop never ends on the cycle it starts
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         coast <= 0;
         motor_stopped <= 1'b1;
      end
      else if (run_command)
      begin
         coast <= STOP_CYCLES;
         motor_stopped <= 1'b0;
      end
      else if (coast > 0)
         coast <= coast - 1;
      else
         motor_stopped <= 1'b1;
   end
endmodule
`default_nettype wire

// [tb/rfs_select_asserts.sv]
// concurrent checks on the source selector ports
`timescale 1ns/10ps
`default_nettype none
module rfs_select_asserts
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic [7:0]  multi_inputs,
   input wire logic [39:0] multi_input_function_selects,
   input wire logic [2:0]  primary_run_source,
   input wire logic [3:0]  primary_freq_source,
   input wire logic [2:0]  secondary_run_source,
   input wire logic [3:0]  secondary_freq_source,
   input wire logic [1:0]  stop_method_select,
   input wire logic        keypad_stop_key,
   input wire logic        forward_run_input,
   input wire logic        reverse_run_input,
   input wire logic        serial_run,
   input wire logic [15:0] rs485_freq,
   input wire logic        motor_stopped,
   input wire logic        secondary_active,
   input wire logic [2:0]  active_run_source,
   input wire logic [3:0]  active_freq_source,
   input wire logic        run_command,
   input wire logic        reverse_command,
   input wire logic [17:0] freq_reference,
   input wire logic        decel_request,
   input wire logic [1:0]  decel_method,
   input wire logic        source_switched,
   input wire logic        source_code_error
);
   logic sec_now;
   logic live;
   integer i;
   // any terminal coded for secondary switching that is on
   always @*
   begin
      sec_now = 1'b0;
      for (i = 0; i < 8; i = i + 1)
         if (multi_inputs[i] && multi_input_function_selects[5*i +: 5] == 5'h16)
            sec_now = 1'b1;
   end
   // outputs carry reset values at the first edge, so checks wait one more
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         live <= 1'b0;
      else
         live <= 1'b1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sec_follow_a: assert property (live |-> secondary_active == $past(sec_now))
      else $error("secondary_active does not follow coded terminal");
   run_pick_a: assert property (live |-> active_run_source == ($past(sec_now) ?
      $past(secondary_run_source) : $past(primary_run_source))) else $error("wrong run source");
   freq_pick_a: assert property (live |-> active_freq_source == ($past(sec_now) ?
      $past(secondary_freq_source) : $past(primary_freq_source))) else $error("wrong freq source");
   switch_pulse_a: assert property (live |-> source_switched == $changed(secondary_active))
      else $error("source_switched wrong");
   code_error_a: assert property (source_code_error == (active_run_source > 3'h4 || active_freq_source > 4'h9))
      else $error("source_code_error wrong");
   term_fr_a: assert property (live && active_run_source == 3'h1 |->
      run_command == ($past(forward_run_input) ^ $past(reverse_run_input))) else $error("fwd/rev run wrong");
   term_rd_a: assert property (live && active_run_source == 3'h2 |-> run_command == $past(forward_run_input)
      && (!run_command || reverse_command == $past(reverse_run_input))) else $error("run/dir wrong");
   serial_run_a: assert property (live && active_run_source == 3'h3 |-> run_command == $past(serial_run))
      else $error("serial run wrong");
   keypad_stop_a: assert property (live && active_run_source == 3'h0 && $past(keypad_stop_key) |-> !run_command)
      else $error("keypad stop ignored");
   decel_start_a: assert property ($fell(run_command) |-> decel_request && decel_method == $past(stop_method_select))
      else $error("no decel on stop");
   decel_end_a: assert property (decel_request && motor_stopped |=> !decel_request)
      else $error("decel not ended");
   rs485_ref_a: assert property (live && active_freq_source == 4'h7 |-> freq_reference == {2'h0, $past(rs485_freq)})
      else $error("rs485 reference wrong");
endmodule
bind rfs_select rfs_select_asserts u_rfs_select_asserts (.clock, .rst, .multi_inputs, .multi_input_function_selects,
   .primary_run_source, .primary_freq_source, .secondary_run_source, .secondary_freq_source, .stop_method_select,
   .keypad_stop_key, .forward_run_input, .reverse_run_input, .serial_run, .rs485_freq, .motor_stopped,
   .secondary_active, .active_run_source, .active_freq_source, .run_command, .reverse_command, .freq_reference,
   .decel_request, .decel_method, .source_switched, .source_code_error);
`default_nettype wire

// [tb/rfs_select_tb_top.sv]
// self-checking bench for the run and frequency source selector
`timescale 1ns/10ps
`default_nettype none
module rfs_select_tb_top;
   logic clock, rst, keypad_run_key, keypad_stop_key, keypad_reverse, forward_run_input, reverse_run_input;
   logic serial_run, serial_reverse, fieldbus_run, fieldbus_reverse;
   logic [7:0] multi_inputs;
   logic [39:0] multi_input_function_selects;
   logic [2:0] primary_run_source, secondary_run_source;
   logic [3:0] primary_freq_source, secondary_freq_source;
   logic [1:0] stop_method_select;
   logic [15:0] keypad_freq_one, keypad_freq_two, voltage_ref_input, current_ref_input, rs485_freq, updown_freq;
   logic [15:0] fieldbus_freq;
   wire logic motor_stopped, secondary_active, run_command, reverse_command, decel_request, source_switched;
   wire logic source_code_error;
   wire logic [2:0] active_run_source;
   wire logic [3:0] active_freq_source;
   wire logic [17:0] freq_reference;
   wire logic [1:0] decel_method;
   integer n_mismatch = 0;
   integer num_checks = 0;
   integer cycles = 0;
   rfs_select u_rfs_select (.clock, .rst, .multi_inputs, .multi_input_function_selects, .primary_run_source,
      .primary_freq_source, .secondary_run_source, .secondary_freq_source, .stop_method_select, .keypad_run_key,
      .keypad_stop_key, .keypad_reverse, .forward_run_input, .reverse_run_input, .serial_run, .serial_reverse,
      .fieldbus_run, .fieldbus_reverse, .keypad_freq_one, .keypad_freq_two, .voltage_ref_input, .current_ref_input,
      .rs485_freq, .updown_freq, .fieldbus_freq, .motor_stopped, .secondary_active, .active_run_source,
      .active_freq_source, .run_command, .reverse_command, .freq_reference, .decel_request, .decel_method,
      .source_switched, .source_code_error);
   rfs_motor_model #(.STOP_CYCLES(6)) u_rfs_motor_model (.clock, .rst, .run_command, .motor_stopped);
   // free-running clock, 25 ns period
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // hang guard, far beyond the sixty or so cycles the tests need
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_mismatch = n_mismatch + 1;
         finish_test;
      end
   end
   task finish_test;
   begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   task chk(input string what, input logic [17:0] exp, input logic [17:0] got);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   end
   endtask
   // one rising edge between driving at a falling edge and looking
   task tick;
      @(negedge clock);
   endtask
   // negative volts expose clamping and sign extension in the sums
   task t_freq;
      integer c;
      logic [17:0] e [0:10];
   begin
      e = '{18'h00101, 18'h00202, 18'h3F000, 18'h00000, 18'h02000, 18'h01000, 18'h02000,
            18'h00707, 18'h00808, 18'h00909, 18'h00000};
      for (c = 0; c < 11; c = c + 1)
      begin
         primary_freq_source = c[3:0];
         tick;
         chk("freq_reference", e[c], freq_reference);
         chk("source_code_error", 18'(c > 9), source_code_error);
      end
      primary_freq_source = 4'h0;
      $display("test freq sources done");
   end
   endtask
   // {code, fwd, rev, serial, fieldbus, run, reverse, error}; serial and fieldbus directions differ
   task t_run;
      integer i;
      logic [9:0] t [0:6];
   begin
      t = '{10'h0C4, 10'h0A6, 10'h0E0, 10'h166, 10'h196, 10'h20C, 10'h281};
      {serial_reverse, fieldbus_reverse} = 2'h2;
      for (i = 0; i < 7; i = i + 1)
      begin
         {primary_run_source, forward_run_input, reverse_run_input, serial_run, fieldbus_run} = t[i][9:3];
         tick;
         chk("run_command", 18'(t[i][2]), run_command);
         if (t[i][2])
            chk("reverse_command", 18'(t[i][1]), reverse_command);
         chk("source_code_error", 18'(t[i][0]), source_code_error);
      end
      $display("test run sources done");
   end
   endtask
   task t_keypad;
   begin
      {primary_run_source, forward_run_input, keypad_run_key} = 5'h01;
      keypad_reverse = 1'b1;
      tick;
      keypad_run_key = 1'b0;
      forward_run_input = 1'b1;
      tick;
      chk("run_command", 18'h1, run_command);
      chk("reverse_command", 18'h1, reverse_command);
      keypad_stop_key = 1'b1;
      tick;
      keypad_stop_key = 1'b0;
      tick;
      chk("run_command", 18'h0, run_command);
      $display("test keypad done");
   end
   endtask
   task wait_stop;
      integer k;
   begin
      for (k = 0; k < 20 && decel_request !== 1'b0; k = k + 1)
         tick;
      chk("decel_request", 18'h0, decel_request);
   end
   endtask
   // terminal 1 on but coded 0 must not switch; only terminal 8 coded 22
   task t_switch;
   begin
      multi_input_function_selects = {5'h16, 35'h0};
      {primary_run_source, secondary_run_source, secondary_freq_source} = {3'h3, 3'h1, 4'h7};
      {serial_run, forward_run_input, multi_inputs} = {2'h3, 8'h01};
      tick;
      chk("active_run_source", 18'h3, active_run_source);
      multi_inputs = 8'h81;
      tick;
      chk("source_switched", 18'h1, source_switched);
      chk("active_run_source", 18'h1, active_run_source);
      chk("secondary_active", 18'h1, secondary_active);
      chk("active_freq_source", 18'h7, active_freq_source);
      chk("freq_reference", 18'h00707, freq_reference);
      chk("run_command", 18'h1, run_command);
      chk("decel_request", 18'h0, decel_request);
      {serial_run, stop_method_select, multi_inputs} = {3'h2, 8'h01};
      tick;
      chk("source_switched", 18'h1, source_switched);
      chk("run_command", 18'h0, run_command);
      chk("decel_method", 18'h2, decel_method);
      wait_stop;
      {serial_run, forward_run_input, stop_method_select} = 4'h9;
      tick;
      multi_inputs = 8'h80;
      tick;
      chk("decel_request", 18'h1, decel_request);
      chk("decel_method", 18'h1, decel_method);
      wait_stop;
      $display("test source switching done");
   end
   endtask
   // main sequence, inputs driven at falling edges
   initial
   begin
      {keypad_run_key, keypad_stop_key, keypad_reverse, forward_run_input, reverse_run_input} = 5'h00;
      {serial_run, serial_reverse, fieldbus_run, fieldbus_reverse, multi_inputs} = 12'h100;
      multi_input_function_selects = 40'h0;
      {primary_run_source, secondary_run_source, primary_freq_source, secondary_freq_source} = 14'h1000;
      stop_method_select = 2'h0;
      {keypad_freq_one, keypad_freq_two, voltage_ref_input} = {16'h0101, 16'h0202, 16'hF000};
      {current_ref_input, rs485_freq, updown_freq, fieldbus_freq} = {16'h2000, 16'h0707, 16'h0808, 16'h0909};
      rst = 1'b1;
      repeat (16) @(negedge clock);
      rst = 1'b0;
      tick;
      t_freq;
      t_run;
      t_keypad;
      t_switch;
      finish_test;
   end
endmodule
`default_nettype wire
